// ===== shared/cfg_loader_pkg.sv
// Purpose: Constants shared by the preload field loader and its bench.
// Assumes: 16-bit preload words, byte addressed in the store.
// Notes:   Register offsets are byte addresses on the AXI4-Lite port.
package cfg_loader_pkg;

  // ****************************************
  // Preload word addresses in the store
  // ****************************************
  localparam logic [7:0]  EE_PB    = 8'h60;     // Power budget, port 0
  localparam logic [7:0]  EE_SVID  = 8'h68;     // Subsystem vendor, func 0
  localparam logic [7:0]  EE_F1    = 8'h6E;     // Func 1 capability control
  localparam logic [7:0]  EE_PHY   = 8'h70;     // Phy control high, port 0
  localparam logic [7:0]  EE_SSID  = 8'h78;     // Subsystem id, func 0
  localparam logic [7:0]  EE_CDR   = 8'h80;     // Phy control low, port 0
  localparam logic [7:0]  EE_STEP  = 8'h02;     // Distance between ports

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int          PB_W     = 13;        // Base power, scale, state
  localparam int          SYS_BIT  = 15;        // System allocated flag
  localparam int          F1_W     = 11;        // Capability control width
  localparam logic [15:0] F1_MASK  = 16'h04EF;  // Bits 3:0, 7:5 and 10
  localparam int          PHY_W    = 15;        // Lands in bits 30:16
  localparam int          CDR_W    = 5;         // Lands in bits 12:8

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  RA_CTRL  = 8'h00;     // Restart and hold
  localparam logic [7:0]  RA_STAT  = 8'h04;     // Done, ready, count
  localparam logic [7:0]  RA_INJ   = 8'h08;     // Software preload word
  localparam logic [7:0]  RA_PB    = 8'h10;     // Power budget, per port
  localparam logic [7:0]  RA_SUB   = 8'h20;     // Subsystem ids, per func
  localparam logic [7:0]  RA_F1    = 8'h30;     // Func 1 control
  localparam logic [7:0]  RA_PHY   = 8'h40;     // Phy control, per port
  localparam logic [7:0]  RA_STEP  = 8'h04;     // Word stride
  localparam int          RESTART_BIT = 0;      // Ctrl: restart load
  localparam int          HOLD_BIT    = 1;      // Ctrl: hold ready low
  localparam int          INJ_A_LSB   = 16;     // Inject: store address
  localparam int          CNT_LSB     = 8;      // Status: word count
  localparam int          PB_SYS_POS  = 16;     // Pb reg: system allocated
  localparam int          PHY_LO_POS  = 8;      // Phy reg: low field
  localparam int          PHY_HI_POS  = 16;     // Phy reg: high field
  localparam logic [1:0]  RESP_OKAY   = 2'h0;   // Bus answer okay
  localparam logic [1:0]  RESP_SLVERR = 2'h2;   // Bus answer error
  localparam logic [3:0]  STRB_ALL    = 4'hF;   // Full word strobe

endpackage

// ===== design/cfg_loader.sv
// Purpose: Copies preload words into per-port and per-function fields.
// Assumes: Word strobe and load end come from logic on aclk.
// Notes:   Fields freeze once loading ends, until a ctrl restart reopens it; bus shows them read only.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - Words 60h-64h fill port power budget
// R2 - Base power, scale, state keep positions
// R3 - Word bit 15 gives system allocated
// R4 - Words 68h-6Ch fill subsystem vendor ids
// R5 - Words 78h-7Ch fill subsystem ids
// R6 - Word 6Eh sets func 1 reporting enables
// R7 - Payload size and aux power too
// R8 - Words 70h-74h fill phy bits 30:16
// R9 - Bits 3:0 are drive offset enables
// R10 - Signal detect and equalization fields copied
// R11 - Reserved bits copied, bit 14 swing
// R12 - Word 80h fills port 0 bits 12:8
// R13 - Finish before ready; unmapped bits ignored
module cfg_loader
  import cfg_loader_pkg::*;
#(
  parameter int NPORT = 3,                          // Ports and functions
  parameter int AW    = 8                           // Bus address width
)(
  input  wire logic                      aclk,        // Core clock
  input  wire logic                      aresetn,     // Sync reset, low
  input  wire logic                      word_valid,  // Preload word strobe
  input  wire logic [7:0]                word_addr,   // Store byte address
  input  wire logic [15:0]               word_data,   // Preload word
  input  wire logic                      load_done,   // Store read finished
  output logic                           cfg_ready,   // Config may answer
  output logic [NPORT-1:0][PB_W-1:0]     pb_out,      // 214h bits 12:0
  output logic [NPORT-1:0]               sys_alloc,   // 218h bit 0
  output logic [NPORT-1:0][15:0]         svid_out,    // 2Ch-2Dh
  output logic [NPORT-1:0][15:0]         ssid_out,    // 2Eh-2Fh
  output logic [F1_W-1:0]                f1_ctl,      // Func 1 E8h 10:0
  output logic [NPORT-1:0][PHY_W-1:0]    phy_hi,      // BCh bits 30:16
  output logic [CDR_W-1:0]               cdr0,        // Port 0 BCh 12:8
  input  wire logic [AW-1:0]             awaddr,      // Write address
  input  wire logic                      awvalid,     // Write address valid
  output logic                           awready,     // Write address ready
  input  wire logic [31:0]               wdata,       // Write data
  input  wire logic [3:0]                wstrb,       // Byte enables
  input  wire logic                      wvalid,      // Write data valid
  output logic                           wready,      // Write data ready
  output logic [1:0]                     bresp,       // Write answer
  output logic                           bvalid,      // Write answer valid
  input  wire logic                      bready,      // Write answer ready
  input  wire logic [AW-1:0]             araddr,      // Read address
  input  wire logic                      arvalid,     // Read address valid
  output logic                           arready,     // Read address ready
  output logic [31:0]                    rdata,       // Read data
  output logic [1:0]                     rresp,       // Read answer
  output logic                           rvalid,      // Read answer valid
  input  wire logic                      rready       // Read answer ready
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NPORT-1:0][PB_W-1:0]  pb;      // Power budget fields
    logic [NPORT-1:0]            sys;     // System allocated flags
    logic [NPORT-1:0][15:0]      svid;    // Subsystem vendor ids
    logic [NPORT-1:0][15:0]      ssid;    // Subsystem ids
    logic [F1_W-1:0]             f1;      // Func 1 control
    logic [NPORT-1:0][PHY_W-1:0] phy;     // Phy control high
    logic [CDR_W-1:0]            cdr;     // Port 0 phy control low
    logic                        done;    // Loading finished
    logic                        hold;    // Software holds ready low
    logic [7:0]                  cnt;     // Mapped words taken
    logic                        ready;   // Config may answer
    logic                        awrdy;   // Bus write address ready
    logic                        wrdy;    // Bus write data ready
    logic                        aw_ok;   // Write address held
    logic                        w_ok;    // Write data held
    logic [AW-1:0]               awa;     // Held write address
    logic [31:0]                 wd;      // Held write data
    logic [3:0]                  ws;      // Held strobes
    logic                        bv;      // Write answer valid
    logic [1:0]                  br;      // Write answer code
    logic                        arrdy;   // Read address ready
    logic                        rv;      // Read answer valid
    logic [31:0]                 rd;      // Read data
    logic [1:0]                  rr;      // Read answer code
  } st_t;

  st_t  st_q;                                       // Registered state
  st_t  st_d;                                       // Next state
  logic take;                                       // Word accepted now

  // ****************************************
  // Helpers
  // ****************************************
  // Store address of slot n in a three-port group
  function automatic logic hit(logic [7:0] a, logic [7:0] base, int n);
    return a == 8'(base + EE_STEP * 8'(n));
  endfunction

  // Copy one preload word into its fields
  function automatic st_t apply(st_t s, logic [7:0] a, logic [15:0] d);
    st_t  r;
    logic m;
    r = s;
    m = 1'b0;
    for (int i = 0; i < NPORT; i++)
    begin
      if (hit(a, EE_PB, i))
      begin
        r.pb[i]  = d[PB_W-1:0];                     // [R1] [R2]
        r.sys[i] = d[SYS_BIT];                      // [R3]
        m        = 1'b1;
      end
      if (hit(a, EE_SVID, i))
      begin
        r.svid[i] = d;                              // [R4]
        m         = 1'b1;
      end
      if (hit(a, EE_SSID, i))
      begin
        r.ssid[i] = d;                              // [R5]
        m         = 1'b1;
      end
      if (hit(a, EE_PHY, i))
      begin
        r.phy[i] = d[PHY_W-1:0];                    // [R8] [R9] [R10] [R11]
        m        = 1'b1;
      end
    end
    if (a == EE_F1)
    begin
      r.f1 = F1_W'(d & F1_MASK);                    // [R6] [R7] [R13]
      m    = 1'b1;
    end
    if (a == EE_CDR)
    begin
      r.cdr = d[CDR_W-1:0];                         // [R12]
      m     = 1'b1;
    end
    if (m)
      r.cnt = 8'(s.cnt + 8'h01);
    return r;
  endfunction

  // Read mux: error flag above 32 data bits
  function automatic logic [32:0] rd_word(st_t s, logic [AW-1:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    if (a == AW'(RA_CTRL))
      r = {1'b0, 30'h0, s.hold, 1'b0};
    if (a == AW'(RA_STAT))
      r = {1'b0, 16'h0, s.cnt, 6'h0, s.ready, s.done};
    if (a == AW'(RA_INJ))
      r = {1'b0, 32'h0};
    for (int i = 0; i < NPORT; i++)
    begin
      if (a == AW'(RA_PB + RA_STEP * 8'(i)))
        r = {1'b0, (32'(s.sys[i]) << PB_SYS_POS) | 32'(s.pb[i])};
      if (a == AW'(RA_SUB + RA_STEP * 8'(i)))
        r = {1'b0, s.ssid[i], s.svid[i]};
      if (a == AW'(RA_PHY + RA_STEP * 8'(i)))
        r = {1'b0, (32'(s.phy[i]) << PHY_HI_POS)
               | (i == 0 ? 32'(s.cdr) << PHY_LO_POS : 32'h0)};
    end
    if (a == AW'(RA_F1))
      r = {1'b0, 32'(s.f1)};
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  assign take = word_valid && !st_q.done;           // [R13]

  // Bus slave, then loader, then ready
  always_comb
  begin
    logic [32:0] rw;
    rw   = 33'h0;
    st_d = st_q;
    // Write address and data taken in either order
    if (awvalid && st_q.awrdy)
    begin
      st_d.aw_ok = 1'b1;
      st_d.awa   = awaddr;
    end
    if (wvalid && st_q.wrdy)
    begin
      st_d.w_ok = 1'b1;
      st_d.wd   = wdata;
      st_d.ws   = wstrb;
    end
    if (st_q.bv && bready)
      st_d.bv = 1'b0;
    // Both halves held: perform write and answer
    if (st_q.aw_ok && st_q.w_ok && !st_q.bv)
    begin
      st_d.aw_ok = 1'b0;
      st_d.w_ok  = 1'b0;
      st_d.bv    = 1'b1;
      rw         = rd_word(st_q, st_q.awa);
      st_d.br    = rw[32] ? RESP_SLVERR : RESP_OKAY;
      if (st_q.awa == AW'(RA_CTRL) && st_q.ws[0])
      begin
        st_d.hold = st_q.wd[HOLD_BIT];
        if (st_q.wd[RESTART_BIT])
        begin
          st_d.done = 1'b0;                         // Reload allowed again
          st_d.cnt  = 8'h00;
        end
      end
      // Software word only while loading is open
      if (st_q.awa == AW'(RA_INJ) && st_q.ws == STRB_ALL && !st_q.done)
        st_d = apply(st_d, st_q.wd[INJ_A_LSB +: 8], st_q.wd[15:0]);
    end
    // Store word wins over a software word
    if (take)
      st_d = apply(st_d, word_addr, word_data);
    // End of load beats a restart in the same cycle
    if (load_done)
      st_d.done = 1'b1;                             // [R13]
    st_d.ready = st_d.done && !st_d.hold;           // [R13]
    st_d.awrdy = !st_d.aw_ok && !st_d.bv;
    st_d.wrdy  = !st_d.w_ok && !st_d.bv;
    // Read channel: one outstanding
    if (st_q.rv && rready)
      st_d.rv = 1'b0;
    if (arvalid && st_q.arrdy)
    begin
      rw      = rd_word(st_q, araddr);
      st_d.rv = 1'b1;
      st_d.rd = rw[31:0];
      st_d.rr = rw[32] ? RESP_SLVERR : RESP_OKAY;
    end
    st_d.arrdy = !st_d.rv;
  end

  // Register the whole state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cfg_ready = st_q.ready;
  assign pb_out    = st_q.pb;
  assign sys_alloc = st_q.sys;
  assign svid_out  = st_q.svid;
  assign ssid_out  = st_q.ssid;
  assign f1_ctl    = st_q.f1;
  assign phy_hi    = st_q.phy;
  assign cdr0      = st_q.cdr;
  assign awready   = st_q.awrdy;
  assign wready    = st_q.wrdy;
  assign bvalid    = st_q.bv;
  assign bresp     = st_q.br;
  assign arready   = st_q.arrdy;
  assign rvalid    = st_q.rv;
  assign rdata     = st_q.rd;
  assign rresp     = st_q.rr;

  // ****************************************
  // Checks
  // ****************************************
  // Port 1 power budget word lands in 12:0
  property p_pb;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h62 |=> pb_out[1] == 13'($past(word_data));
  endproperty
  a_pb: assert property (p_pb) else $error("power budget not loaded"); // [R1] [R2]

  // Port 2 bit 15 to system allocated
  property p_sys;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h64 |=> sys_alloc[2] == $past(word_data[15]);
  endproperty
  a_sys: assert property (p_sys) else $error("system allocated wrong"); // [R3]

  // Func 0 subsystem vendor id
  property p_svid;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h68 |=> svid_out[0] == $past(word_data);
  endproperty
  a_svid: assert property (p_svid) else $error("vendor id not loaded"); // [R4]

  // Func 2 subsystem id
  property p_ssid;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h7C |=> ssid_out[2] == $past(word_data);
  endproperty
  a_ssid: assert property (p_ssid) else $error("subsystem id not loaded"); // [R5]

  // Func 1 control keeps only mapped bits
  property p_f1;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h6E |=> f1_ctl == 11'($past(word_data) & F1_MASK);
  endproperty
  a_f1: assert property (p_f1) else $error("func 1 control wrong"); // [R6] [R7]

  // Port 0 phy high field copies bits 14:0
  property p_phy;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h70 |=> phy_hi[0] == 15'($past(word_data));
  endproperty
  a_phy: assert property (p_phy) else $error("phy control wrong"); // [R8] [R9] [R10] [R11]

  // Port 0 clock recovery field
  property p_cdr;
    @(posedge aclk) disable iff (!aresetn)
    take && word_addr == 8'h80 |=> cdr0 == 5'($past(word_data));
  endproperty
  a_cdr: assert property (p_cdr) else $error("recovery field wrong"); // [R12]

  // Ready rises only on a load end or a hold release
  property p_rdy;
    @(posedge aclk) disable iff (!aresetn)
    $rose(cfg_ready) |-> $past(load_done) || $fell(st_q.hold);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready before load end"); // [R13]

  // Power budget, phy high and vendor id fields frozen once loading ended
  property p_frz;
    @(posedge aclk) disable iff (!aresetn)
    st_q.done |=> $stable(pb_out) && $stable(phy_hi) && $stable(svid_out);
  endproperty
  a_frz: assert property (p_frz) else $error("field moved after load"); // [R13]

  // Read answer one cycle after address taken
  property p_rd;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid ##0 !arready;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");

endmodule // cfg_loader

`default_nettype wire

// ===== test/preload_store.sv
// Purpose: Store model that streams preload words to the loader.
// Assumes: Words sit at 60h..80h, one word per strobe.
// Notes:   Between strobes the lines show inverted data, never the last word.
`timescale 1ns/1ps
`default_nettype none
module preload_store (
  input  wire logic   aclk,        // Core clock
  input  wire logic   start,       // Begin one pass
  input  wire logic   slow,        // Gaps between words
  output logic        word_valid,  // Word strobe
  output logic [7:0]  word_addr,   // Store byte address
  output logic [15:0] word_data,   // Word value
  output logic        load_done    // Pass finished
);
  logic [15:0] mem [17];           // Words 60h..80h

  // One pass per start, back to back or with gaps
  initial
  begin
    word_valid = 1'b0;
    load_done  = 1'b0;
    word_addr  = 8'hFF;
    word_data  = 16'hFFFF;
    forever
    begin
      @(posedge aclk);
      if (start)
      begin
        for (int i = 0; i < 17; i++)
        begin
          word_valid <= 1'b1;
          word_addr  <= 8'h60 + 8'(2 * i);
          word_data  <= mem[i];
          @(posedge aclk);
          if (slow)
          begin
            word_valid <= 1'b0;
            word_addr  <= ~word_addr;
            word_data  <= ~word_data;
            repeat (2) @(posedge aclk);
          end
        end
        // Release the lines and flag the end in the same cycle
        word_valid <= 1'b0;
        word_addr  <= ~8'h80;
        word_data  <= ~mem[16];
        load_done  <= 1'b1;
        @(posedge aclk);
        load_done  <= 1'b0;
      end
    end
  end
endmodule // preload_store
`default_nettype wire

// ===== test/tb_cfg_loader.sv
// Purpose: Self-checking bench for the preload field loader.
// Assumes: Store model feeds words; registers read over AXI4-Lite.
// Notes:   Rows hold store words beside the register word they give.
`timescale 1ns/1ps
`default_nettype none
module tb_cfg_loader
  import cfg_loader_pkg::*;
;
  typedef struct packed {
    logic [7:0] a0; logic [15:0] d0; logic [7:0] a1; logic [15:0] d1; logic [7:0] ra; logic [31:0] ex;
  } row_t;
  logic                   aclk = 1'b0;  // Core clock
  logic                   aresetn, start, slow, word_valid, load_done, cfg_ready;
  logic [7:0]             word_addr, awaddr, araddr;
  logic [15:0]            word_data;
  logic [2:0][PB_W-1:0]   pb_out;       // Power budget fields
  logic [2:0]             sys_alloc;    // System allocated flags
  logic [2:0][15:0]       svid_out, ssid_out;
  logic [F1_W-1:0]        f1_ctl;       // Func 1 control
  logic [2:0][PHY_W-1:0]  phy_hi;       // Phy high fields
  logic [CDR_W-1:0]       cdr0;         // Port 0 low field
  logic                   awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  int                     n_fail, num_checks, cycles;
  row_t                   rows [10];    // Ordinary cases

  cfg_loader i_cfg_loader (.aclk(aclk), .aresetn(aresetn), .word_valid(word_valid), .word_addr(word_addr),
    .word_data(word_data), .load_done(load_done), .cfg_ready(cfg_ready), .pb_out(pb_out), .sys_alloc(sys_alloc),
    .svid_out(svid_out), .ssid_out(ssid_out), .f1_ctl(f1_ctl), .phy_hi(phy_hi), .cdr0(cdr0), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  preload_store i_preload_store (.aclk(aclk), .start(start), .slow(slow), .word_valid(word_valid),
    .word_addr(word_addr), .word_data(word_data), .load_done(load_done));

  // Clock and hang guard
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data together, wait for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    int   n;
    ad = 1'b0;
    wd = 1'b0;
    n  = 0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      awvalid <= ~ad;
      wvalid  <= ~wd;
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    check(32'(bvalid), 32'h1);
    check(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask

  // Bus read with expected word and answer
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    logic ad;
    int   n;
    ad = 1'b0;
    n  = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      ad = ad | (arready === 1'b1);
      arvalid <= ~ad;
      if (rvalid === 1'b1)
        break;
    end
    rready <= 1'b0;
    check(32'(rvalid), 32'h1);
    check(rdata, ex);
    check(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask

  // Start a store pass; config must stay closed until it ends
  task automatic pass(input logic s);
    int n;
    n = 0;
    slow  <= s;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    while (n < 300 && load_done !== 1'b1)
    begin
      @(posedge aclk);
      n++;
      if (load_done !== 1'b1)
        check(32'(cfg_ready), 32'h0);
    end
    check(32'(load_done), 32'h1);
    repeat (3) @(posedge aclk);
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {aresetn, start, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = STRB_ALL;
    rows = '{'{8'h60, 16'hFFFF, 8'h60, 16'hFFFF, 8'h10, 32'h0001_1FFF},
             '{8'h62, 16'h7ABC, 8'h62, 16'h7ABC, 8'h14, 32'h0000_1ABC},
             '{8'h64, 16'h8123, 8'h64, 16'h8123, 8'h18, 32'h0001_0123},
             '{8'h68, 16'h1234, 8'h78, 16'h5678, 8'h20, 32'h5678_1234},
             '{8'h6A, 16'hABCD, 8'h7A, 16'h0F0F, 8'h24, 32'h0F0F_ABCD},
             '{8'h6C, 16'h8001, 8'h7C, 16'hFEDC, 8'h28, 32'hFEDC_8001},
             '{8'h6E, 16'hFFFF, 8'h6E, 16'hFFFF, 8'h30, 32'h0000_04EF},
             '{8'h70, 16'hFFFF, 8'h80, 16'hFFFF, 8'h40, 32'h7FFF_1F00},
             '{8'h72, 16'h4A5A, 8'h72, 16'h4A5A, 8'h44, 32'h4A5A_0000},
             '{8'h74, 16'hB5A5, 8'h74, 16'hB5A5, 8'h48, 32'h35A5_0000}};
    for (int i = 0; i < 17; i++)
      i_preload_store.mem[i] = 16'hFFFF;
    foreach (rows[i])
    begin
      i_preload_store.mem[(rows[i].a0 - 8'h60) >> 1] = rows[i].d0;
      i_preload_store.mem[(rows[i].a1 - 8'h60) >> 1] = rows[i].d1;
    end
    repeat (12) @(posedge aclk);
    check(32'({cfg_ready, awready, wready, arready}), 32'h0);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(RA_STAT, 32'h0, RESP_OKAY);
    rd(RA_PB, 32'h0, RESP_OKAY);
    pass(1'b0);
    check(32'(cfg_ready), 32'h1);
    rd(RA_STAT, 32'h0000_0E03, RESP_OKAY);
    foreach (rows[i])
      rd(rows[i].ra, rows[i].ex, RESP_OKAY);
    check(32'(pb_out[2]), 32'h0123);
    check(32'(sys_alloc), 32'h5);
    check({svid_out[1], ssid_out[2]}, 32'hABCD_FEDC);
    check(32'(f1_ctl), 32'h04EF);
    check({1'h0, phy_hi[1], 11'h0, cdr0}, 32'h4A5A_001F);
    // Refused and ignored accesses
    rd(8'h0C, 32'h0, RESP_SLVERR);
    rd(8'h12, 32'h0, RESP_SLVERR);
    wr(8'h50, 32'h1, RESP_SLVERR);
    wr(RA_PB, 32'h0, RESP_OKAY);
    wr(RA_INJ, 32'h0060_0000, RESP_OKAY);
    rd(RA_PB, 32'h0001_1FFF, RESP_OKAY);
    // Restart with hold, inject, then a slow pass
    wr(RA_CTRL, 32'h3, RESP_OKAY);
    rd(RA_STAT, 32'h0, RESP_OKAY);
    wr(RA_INJ, 32'h0062_0005, RESP_OKAY);
    rd(8'h14, 32'h0000_0005, RESP_OKAY);
    pass(1'b1);
    check(32'(cfg_ready), 32'h0);
    rd(8'h14, 32'h0000_1ABC, RESP_OKAY);
    wr(RA_CTRL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(cfg_ready), 32'h1);
    summarize();
  end
endmodule // tb_cfg_loader
`default_nettype wire
